// ===== rtl/setpoint_consts.svh
// offsets, field positions, defaults and timing counts of the setpoint block
`ifndef SETPOINT_CONSTS_SVH
`define SETPOINT_CONSTS_SVH

// register byte offsets
`define OFS_CONFIG    8'h00
`define OFS_SPLIT     8'h04
`define OFS_LIMIT     8'h08
`define OFS_TIME      8'h0c
`define OFS_CONTROL   8'h10
`define OFS_COMMAND   8'h14
`define OFS_STATUS    8'h18
`define OFS_POSITION  8'h1c
`define OFS_NV_BASE   8'h20
`define OFS_NV_LAST   8'h2c

// config and command fields
`define BIT_RANGE_0_20  0
`define BIT_THREE_WIRE  1
`define BIT_DIR_INVERSE 2
`define BIT_CTRL_PARAM  3
`define BIT_CMD_FACTORY 0
`define BIT_CMD_CAL     1

// fixed point scale: 100 % of stroke or signal is 10000 units
`define FULL_SCALE    32'h0000_2710
`define CODE_4MA      32'h0000_0333
`define CODE_SPAN_420 32'h0000_0ccc
`define CODE_FULL     32'h0000_0fff

// adjustment ranges in percent or seconds
`define SPLIT_LO_MAX  8'h4b
`define SPLIT_HI_MIN  8'h19
`define LIMIT_LO_MAX  8'h32
`define LIMIT_HI_MIN  8'h32
`define LIMIT_GAP     8'h32
`define PCT_MAX       8'h64
`define TIME_MAX_S    8'h3c
`define TIME_MIN_S    8'h01

// factory defaults
`define DEF_SPLIT_LO  8'h00
`define DEF_SPLIT_HI  8'h64
`define DEF_LIMIT_LO  8'h00
`define DEF_LIMIT_HI  8'h64
`define DEF_TIME_S    8'h01
`define DEF_DEADBAND  8'h01
`define DEF_GAIN      8'h10

// timing: control update every 100 us, 10000 updates a second
`define CLK_PERIOD_NS   5
`define TICK_TIME_NS    100000
`define TICKS_PER_S     32'h0000_2710
`define CAL_TIMEOUT_T   20'hea60
`define CAL_END_BAND    32'h0000_0064
`define CAL_MOVE_STEP   32'h0000_0032
`define CAL_DB_DIV      20'h0064
`define CAL_DB_MAX      8'h0a

`endif

// ===== rtl/setpoint_pkg.sv
// types shared by the setpoint conditioning block
package setpoint_pkg;
	typedef enum logic [4:0] {
		CAL_IDLE  = 5'b00001,
		CAL_CLOSE = 5'b00010,
		CAL_OPEN  = 5'b00100,
		CAL_SHUT  = 5'b01000,
		CAL_STORE = 5'b10000
	} cal_state_e;
	typedef logic [13:0] pos_t;
endpackage

// ===== rtl/param_mem.sv
// small nonvolatile parameter image with registered read data
`timescale 1ns/100ps
module param_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	// storage array, no reset so it maps to memory
	always_ff @(posedge pclk) begin
		if (we) begin
			mem_reg[waddr] <= wdata;
		end
	end

	// read data registered, one cycle after the address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem_reg[raddr];
		end
	end
endmodule

// ===== rtl/rate_limiter.sv
// ramps the setpoint by one unit every time_s updates
`timescale 1ns/100ps
module rate_limiter
	import setpoint_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick,
	input  wire logic       load,
	input  setpoint_pkg::pos_t load_val,
	input  setpoint_pkg::pos_t target,
	input  wire logic [7:0] open_s,
	input  wire logic [7:0] close_s,
	output setpoint_pkg::pos_t ramp
);
	logic [7:0] div_reg;

	// 10000 units over time_s seconds at 10 kHz is one unit per time_s ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp    <= '0;
			div_reg <= 8'h00;
		end else if (load) begin
			ramp    <= load_val;
			div_reg <= 8'h00;
		end else if (tick && ramp != target) begin
			if (div_reg + 8'h01 >= ((target > ramp) ? open_s : close_s)) begin
				div_reg <= 8'h00;
				ramp    <= (target > ramp) ? ramp + 14'h0001 : ramp - 14'h0001;
			end else begin
				div_reg <= div_reg + 8'h01;
			end
		end else if (tick) begin
			div_reg <= 8'h00;
		end
	end
endmodule

// ===== rtl/setpoint_ctrl.sv
// setpoint conditioning and position control with APB configuration
// Functional notes
// - input range 4-20 or 0-20 mA, 3/4-wire
// - factory reset restores every parameter default
// - calibration starts only with manual switch off
// - calibration moves valve itself, ignoring setpoint
// - successful calibration stores parameters without request
// - direction maps aeration to 0 or 100 %
// - split range rescaled onto full stroke
// - split low 0-75 %, high 25-100 %
// - limited stroke is 100 %, outside reported
// - stroke limits low 0-50, high 50-100
// - limits kept 50 % apart, other adjusted
// - full stroke open/close not faster than times
// - calibration loads minimum times, entries above them
// - react only beyond deadband of scaled range
// - calibration derives deadband from friction when enabled
// - separate open and close gains
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps
`include "setpoint_consts.svh"
module setpoint_ctrl #(
	parameter int TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [11:0] setpoint_code,
	input  wire logic [13:0] position_code,
	input  wire logic        manual_switch,
	output logic             drive_aerate,
	output logic             drive_vent,
	output logic      [7:0]  drive_gain
);
	import setpoint_pkg::*;

	// configuration
	logic       range_0_20_reg, three_wire_reg, dir_inverse_reg, ctrl_param_reg;
	logic [7:0] split_lo_reg, split_hi_reg, limit_lo_reg, limit_hi_reg;
	logic [7:0] open_s_reg, close_s_reg, open_min_reg, close_min_reg;
	logic [7:0] deadband_reg, gain_open_reg, gain_close_reg;
	logic       reject_reg, cal_done_reg, cal_fail_reg;
	// synchronisers
	logic [11:0] sp_meta_reg, sp_sync_reg;
	logic [13:0] pos_meta_reg, pos_sync_reg;
	logic        man_meta_reg, man_sync_reg;
	// control path
	logic [31:0]        tick_cnt_reg;
	logic               tick_reg;
	setpoint_pkg::pos_t target_reg, ramp, pos_act;
	logic signed [15:0] report_reg;
	cal_state_e         cal_state_reg;
	logic [19:0]        cal_ticks_reg, breakaway_reg;
	logic               moved_reg;
	logic [1:0]         store_idx_reg;
	logic [31:0]        nv_rdata;
	// combinational values
	logic signed [31:0] sig_pct, split_pct, stroke_tgt, span, band, err, rel;
	logic               wr_access, rd_setup, cal_start;
	logic [7:0]         cal_open_s, cal_close_s, cal_db;

	// clamps a scaled value into 0..100 %
	function automatic logic signed [31:0] clamp_pct(input logic signed [31:0] v);
		if (v < 0) begin
			return 0;
		end
		return (v > `FULL_SCALE) ? `FULL_SCALE : v;
	endfunction

	// tick count to whole seconds, rounded up, kept in 1..60
	function automatic logic [7:0] ticks_to_s(input logic [19:0] t);
		logic [31:0] s;
		s = (32'(t) + `TICKS_PER_S - 32'h1) / `TICKS_PER_S;
		if (s < 32'(`TIME_MIN_S)) begin
			return `TIME_MIN_S;
		end
		return (s > 32'(`TIME_MAX_S)) ? `TIME_MAX_S : s[7:0];
	endfunction

	assign wr_access = psel && penable && pwrite;
	assign rd_setup  = psel && !penable && !pwrite;
	assign cal_start = wr_access && paddr == `OFS_COMMAND && pwdata[`BIT_CMD_CAL]
		&& !man_sync_reg && cal_state_reg == CAL_IDLE;

	// pins from the outside world; codes are assumed to change slowly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_meta_reg  <= 12'h000;
			sp_sync_reg  <= 12'h000;
			pos_meta_reg <= 14'h0000;
			pos_sync_reg <= 14'h0000;
			man_meta_reg <= 1'b0;
			man_sync_reg <= 1'b0;
		end else begin
			sp_meta_reg  <= setpoint_code;
			sp_sync_reg  <= sp_meta_reg;
			pos_meta_reg <= position_code;
			pos_sync_reg <= pos_meta_reg;
			man_meta_reg <= manual_switch;
			man_sync_reg <= man_meta_reg;
		end
	end

	// sensor reads aeration; direction turns it into position
	assign pos_act = dir_inverse_reg ? 14'(`FULL_SCALE - 32'(pos_sync_reg)) : pos_sync_reg;

	// setpoint chain: signal percent, split rescale, stroke limit scale
	always_comb begin
		if (range_0_20_reg) begin
			sig_pct = clamp_pct(32'(sp_sync_reg) * `FULL_SCALE / `CODE_FULL);
		end else begin
			sig_pct = clamp_pct($signed((32'(sp_sync_reg) - `CODE_4MA) * `FULL_SCALE) / $signed(`CODE_SPAN_420));
		end
		split_pct = clamp_pct((sig_pct - $signed(32'(split_lo_reg) * 100)) * 100
			/ $signed(32'(split_hi_reg) - 32'(split_lo_reg)));
		span       = 32'(limit_hi_reg) - 32'(limit_lo_reg);
		stroke_tgt = 32'(limit_lo_reg) * 100 + split_pct * span / 100;
		band       = 32'(deadband_reg) * span;
		err        = 32'(ramp) - 32'(pos_act);
		rel        = $signed((32'(pos_act) - 32'(limit_lo_reg) * 100) * 100) / span;
	end

	// control update strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= 32'h0;
			tick_reg     <= 1'b0;
		end else begin
			tick_reg     <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
			tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_reg + 32'h1;
		end
	end

	// target and reported position sampled once per update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target_reg <= '0;
			report_reg <= 16'sh0000;
		end else if (tick_reg) begin
			target_reg <= stroke_tgt[13:0];
			report_reg <= rel[15:0];
		end
	end

	// ramp tracks position during calibration so control resumes without a jump
	rate_limiter u_rate (
		.pclk     (pclk),
		.presetn  (presetn),
		.tick     (tick_reg),
		.load     (cal_state_reg != CAL_IDLE),
		.load_val (pos_act),
		.target   (target_reg),
		.open_s   (open_s_reg),
		.close_s  (close_s_reg),
		.ramp     (ramp)
	);

	// calibration results
	assign cal_open_s  = ticks_to_s(cal_ticks_reg);
	assign cal_close_s = ticks_to_s(cal_ticks_reg);
	assign cal_db = (breakaway_reg / `CAL_DB_DIV >= 20'(`CAL_DB_MAX)) ? `CAL_DB_MAX
		: 8'(breakaway_reg / `CAL_DB_DIV) + 8'h01;

	// calibration sequence: close fully, time the opening, time the closing, store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_state_reg <= CAL_IDLE;
			cal_ticks_reg <= 20'h0;
			breakaway_reg <= 20'h0;
			moved_reg     <= 1'b0;
			store_idx_reg <= 2'h0;
		end else begin
			unique case (cal_state_reg)
				CAL_IDLE: begin
					cal_ticks_reg <= 20'h0;
					store_idx_reg <= 2'h0;
					if (cal_start) begin
						cal_state_reg <= CAL_CLOSE;
					end
				end
				CAL_CLOSE: begin
					if (tick_reg) begin
						cal_ticks_reg <= cal_ticks_reg + 20'h1;
					end
					if (32'(pos_act) <= `CAL_END_BAND) begin
						cal_state_reg <= CAL_OPEN;
						cal_ticks_reg <= 20'h0;
						moved_reg     <= 1'b0;
					end else if (cal_ticks_reg == `CAL_TIMEOUT_T) begin
						cal_state_reg <= CAL_IDLE;
					end
				end
				CAL_OPEN: begin
					if (tick_reg) begin
						cal_ticks_reg <= cal_ticks_reg + 20'h1;
					end
					// first movement after the push shows the static friction
					if (!moved_reg && 32'(pos_act) > `CAL_END_BAND + `CAL_MOVE_STEP) begin
						moved_reg     <= 1'b1;
						breakaway_reg <= cal_ticks_reg;
					end
					if (32'(pos_act) >= `FULL_SCALE - `CAL_END_BAND) begin
						cal_state_reg <= CAL_SHUT;
						cal_ticks_reg <= 20'h0;
					end else if (cal_ticks_reg == `CAL_TIMEOUT_T) begin
						cal_state_reg <= CAL_IDLE;
					end
				end
				CAL_SHUT: begin
					if (tick_reg) begin
						cal_ticks_reg <= cal_ticks_reg + 20'h1;
					end
					if (32'(pos_act) <= `CAL_END_BAND) begin
						cal_state_reg <= CAL_STORE;
					end else if (cal_ticks_reg == `CAL_TIMEOUT_T) begin
						cal_state_reg <= CAL_IDLE;
					end
				end
				CAL_STORE: begin
					store_idx_reg <= store_idx_reg + 2'h1;
					if (store_idx_reg == 2'h3) begin
						cal_state_reg <= CAL_IDLE;
					end
				end
			endcase
		end
	end

	// parameters: apb writes, factory reset, calibration results
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			range_0_20_reg  <= 1'b0;
			three_wire_reg  <= 1'b0;
			dir_inverse_reg <= 1'b0;
			ctrl_param_reg  <= 1'b0;
			split_lo_reg    <= `DEF_SPLIT_LO;
			split_hi_reg    <= `DEF_SPLIT_HI;
			limit_lo_reg    <= `DEF_LIMIT_LO;
			limit_hi_reg    <= `DEF_LIMIT_HI;
			open_s_reg      <= `DEF_TIME_S;
			close_s_reg     <= `DEF_TIME_S;
			open_min_reg    <= `TIME_MIN_S;
			close_min_reg   <= `TIME_MIN_S;
			deadband_reg    <= `DEF_DEADBAND;
			gain_open_reg   <= `DEF_GAIN;
			gain_close_reg  <= `DEF_GAIN;
		end else if (cal_state_reg == CAL_OPEN && 32'(pos_act) >= `FULL_SCALE - `CAL_END_BAND) begin
			open_s_reg   <= cal_open_s;
			open_min_reg <= cal_open_s;
			if (ctrl_param_reg) begin
				deadband_reg <= cal_db;
			end
		end else if (cal_state_reg == CAL_SHUT && 32'(pos_act) <= `CAL_END_BAND) begin
			close_s_reg   <= cal_close_s;
			close_min_reg <= cal_close_s;
		end else if (wr_access && paddr == `OFS_COMMAND && pwdata[`BIT_CMD_FACTORY]) begin
			range_0_20_reg  <= 1'b0;
			three_wire_reg  <= 1'b0;
			dir_inverse_reg <= 1'b0;
			ctrl_param_reg  <= 1'b0;
			split_lo_reg    <= `DEF_SPLIT_LO;
			split_hi_reg    <= `DEF_SPLIT_HI;
			limit_lo_reg    <= `DEF_LIMIT_LO;
			limit_hi_reg    <= `DEF_LIMIT_HI;
			open_s_reg      <= `DEF_TIME_S;
			close_s_reg     <= `DEF_TIME_S;
			open_min_reg    <= `TIME_MIN_S;
			close_min_reg   <= `TIME_MIN_S;
			deadband_reg    <= `DEF_DEADBAND;
			gain_open_reg   <= `DEF_GAIN;
			gain_close_reg  <= `DEF_GAIN;
		end else if (wr_access) begin
			unique case (paddr)
				`OFS_CONFIG: begin
					range_0_20_reg  <= pwdata[`BIT_RANGE_0_20];
					three_wire_reg  <= pwdata[`BIT_THREE_WIRE];
					dir_inverse_reg <= pwdata[`BIT_DIR_INVERSE];
					ctrl_param_reg  <= pwdata[`BIT_CTRL_PARAM];
				end
				`OFS_SPLIT: begin
					if (pwdata[7:0] <= `SPLIT_LO_MAX && pwdata[15:8] >= `SPLIT_HI_MIN
						&& pwdata[15:8] <= `PCT_MAX && pwdata[15:8] > pwdata[7:0]) begin
						split_lo_reg <= pwdata[7:0];
						split_hi_reg <= pwdata[15:8];
					end
				end
				`OFS_LIMIT: begin
					if (pwdata[7:0] <= `LIMIT_LO_MAX && pwdata[15:8] >= `LIMIT_HI_MIN
						&& pwdata[15:8] <= `PCT_MAX) begin
						limit_lo_reg <= pwdata[7:0];
						limit_hi_reg <= pwdata[15:8];
						// the field that changed wins, the low one if both did; the other moves
						if (pwdata[15:8] - pwdata[7:0] < `LIMIT_GAP) begin
							if (pwdata[7:0] != limit_lo_reg) begin
								limit_hi_reg <= pwdata[7:0] + `LIMIT_GAP;
							end else begin
								limit_lo_reg <= pwdata[15:8] - `LIMIT_GAP;
							end
						end
					end
				end
				`OFS_TIME: begin
					if (pwdata[7:0] >= open_min_reg && pwdata[7:0] <= `TIME_MAX_S
						&& pwdata[15:8] >= close_min_reg && pwdata[15:8] <= `TIME_MAX_S) begin
						open_s_reg  <= pwdata[7:0];
						close_s_reg <= pwdata[15:8];
					end
				end
				`OFS_CONTROL: begin
					if (pwdata[7:0] <= `PCT_MAX) begin
						deadband_reg   <= pwdata[7:0];
						gain_open_reg  <= pwdata[15:8];
						gain_close_reg <= pwdata[23:16];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// status flags: a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reject_reg   <= 1'b0;
			cal_done_reg <= 1'b0;
			cal_fail_reg <= 1'b0;
		end else begin
			if (wr_access && ((paddr == `OFS_SPLIT && !(pwdata[7:0] <= `SPLIT_LO_MAX
				&& pwdata[15:8] >= `SPLIT_HI_MIN && pwdata[15:8] <= `PCT_MAX && pwdata[15:8] > pwdata[7:0]))
				|| (paddr == `OFS_LIMIT && !(pwdata[7:0] <= `LIMIT_LO_MAX && pwdata[15:8] >= `LIMIT_HI_MIN
				&& pwdata[15:8] <= `PCT_MAX))
				|| (paddr == `OFS_TIME && !(pwdata[7:0] >= open_min_reg && pwdata[7:0] <= `TIME_MAX_S
				&& pwdata[15:8] >= close_min_reg && pwdata[15:8] <= `TIME_MAX_S))
				|| (paddr == `OFS_CONTROL && pwdata[7:0] > `PCT_MAX))) begin
				reject_reg <= 1'b1;
			end else if (wr_access && paddr == `OFS_STATUS && pwdata[0]) begin
				reject_reg <= 1'b0;
			end
			if (cal_state_reg == CAL_STORE && store_idx_reg == 2'h3) begin
				cal_done_reg <= 1'b1;
			end else if (cal_start) begin
				cal_done_reg <= 1'b0;
			end
			if (cal_state_reg != CAL_IDLE && cal_ticks_reg == `CAL_TIMEOUT_T) begin
				cal_fail_reg <= 1'b1;
			end else if (cal_start) begin
				cal_fail_reg <= 1'b0;
			end
		end
	end

	// nonvolatile image written word by word after a good calibration
	param_mem #(.WIDTH(32), .DEPTH(4), .AW(2)) u_nv (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (cal_state_reg == CAL_STORE),
		.waddr   (store_idx_reg),
		.wdata   ((store_idx_reg == 2'h0) ? {16'h0000, close_s_reg, open_s_reg}
			: (store_idx_reg == 2'h1) ? {16'h0000, close_min_reg, open_min_reg}
			: (store_idx_reg == 2'h2) ? {8'h00, gain_close_reg, gain_open_reg, deadband_reg}
			: {16'h0000, limit_hi_reg, limit_lo_reg}),
		.raddr   (paddr[3:2]),
		.rdata   (nv_rdata)
	);

	// valve drive changes on update strobes only, calibration too, so the valves never chatter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_aerate <= 1'b0;
			drive_vent   <= 1'b0;
			drive_gain   <= 8'h00;
		end else if (tick_reg && cal_state_reg == CAL_OPEN) begin
			drive_aerate <= !dir_inverse_reg;
			drive_vent   <= dir_inverse_reg;
			drive_gain   <= gain_open_reg;
		end else if (tick_reg && (cal_state_reg == CAL_CLOSE || cal_state_reg == CAL_SHUT)) begin
			drive_aerate <= dir_inverse_reg;
			drive_vent   <= !dir_inverse_reg;
			drive_gain   <= gain_close_reg;
		end else if (tick_reg) begin
			if (err > band) begin
				drive_aerate <= !dir_inverse_reg;
				drive_vent   <= dir_inverse_reg;
				drive_gain   <= gain_open_reg;
			end else if (err < -band) begin
				drive_aerate <= dir_inverse_reg;
				drive_vent   <= !dir_inverse_reg;
				drive_gain   <= gain_close_reg;
			end else begin
				drive_aerate <= 1'b0;
				drive_vent   <= 1'b0;
				drive_gain   <= 8'h00;
			end
		end
	end

	// apb read data and error; nv window reads wait one cycle for the memory's read register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= !(rd_setup && paddr >= `OFS_NV_BASE && paddr <= `OFS_NV_LAST);
			pslverr <= psel && !(penable && pready) && !(paddr <= `OFS_NV_LAST && paddr[1:0] == 2'b00);
			if (rd_setup) begin
				unique case (paddr)
					`OFS_CONFIG:   prdata <= {28'h0, ctrl_param_reg, dir_inverse_reg, three_wire_reg, range_0_20_reg};
					`OFS_SPLIT:    prdata <= {16'h0, split_hi_reg, split_lo_reg};
					`OFS_LIMIT:    prdata <= {16'h0, limit_hi_reg, limit_lo_reg};
					`OFS_TIME:     prdata <= {close_min_reg, open_min_reg, close_s_reg, open_s_reg};
					`OFS_CONTROL:  prdata <= {8'h0, gain_close_reg, gain_open_reg, deadband_reg};
					`OFS_STATUS:   prdata <= {27'h0, man_sync_reg, cal_state_reg != CAL_IDLE,
						cal_fail_reg, cal_done_reg, reject_reg};
					`OFS_POSITION: prdata <= {{16{report_reg[15]}}, report_reg};
					default:       prdata <= 32'h0000_0000;
				endcase
			end else if (psel && penable && !pwrite && paddr >= `OFS_NV_BASE && paddr <= `OFS_NV_LAST) begin
				prdata <= nv_rdata;
			end
		end
	end
endmodule

// ===== verification/setpoint_ctrl_chk.sv
// port checker for the setpoint block, bound to its top module
`timescale 1ns/100ps
module setpoint_ctrl_chk #(
	parameter int TICK_CYCLES = 20000
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        drive_aerate,
	input wire logic        drive_vent,
	input wire logic [7:0]  drive_gain
);
	logic [9:0]  prev_reg;
	logic [31:0] since_reg;
	logic        moved;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign moved = {drive_aerate, drive_vent, drive_gain} != prev_reg;
	// cycles since the drive last moved; starts full so release is no change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= 10'h000;
			since_reg <= 32'(TICK_CYCLES);
		end else begin
			prev_reg <= {drive_aerate, drive_vent, drive_gain};
			since_reg <= moved ? 32'h1 : since_reg + 32'h1;
		end
	end
	a_ready_up: assert property ($past(presetn) && !penable |-> pready) else $error("pready low after reset");
	a_ready_access: assert property ($rose(penable) && psel && (pwrite || paddr < 8'h20 || paddr > 8'h2c) |-> pready)
		else $error("access not answered");
	a_nv_wait: assert property ($rose(penable) && psel && !pwrite && paddr >= 8'h20 && paddr <= 8'h2c
		|-> !pready ##1 pready) else $error("nv read not answered after one wait");
	a_err_unmapped: assert property (psel && penable && (paddr > 8'h2c || paddr[1:0] != 2'b00) |-> pslverr)
		else $error("unmapped access without error");
	a_err_mapped: assert property (psel && penable && paddr <= 8'h2c && paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access flagged");
	a_err_phase: assert property (pslverr |-> psel && penable) else $error("error outside access");
	a_drive_excl: assert property (!(drive_aerate && drive_vent)) else $error("aerate and vent together");
	a_drive_tick: assert property (moved |-> since_reg >= 32'(TICK_CYCLES))
		else $error("drive moved between updates");
	a_rdata_hold: assert property (!(psel && !pwrite) |=> $stable(prdata)) else $error("read data moved");
endmodule
bind setpoint_ctrl setpoint_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .drive_aerate(drive_aerate), .drive_vent(drive_vent), .drive_gain(drive_gain));

// ===== verification/actuator_model.sv
// actuator stand-in: aeration raises the sensed position, venting lowers it
`timescale 1ns/100ps
module actuator_model (
	input  wire logic        pclk,
	input  wire logic        drive_aerate,
	input  wire logic        drive_vent,
	input  wire logic        preset_en,
	input  wire logic [13:0] preset_val,
	output logic      [13:0] position_code
);
	initial position_code = 14'h0000;
	// five units a clock keeps a full stroke short; preset pins the stem
	always @(posedge pclk) begin
		if (preset_en)
			position_code <= preset_val;
		else if (drive_aerate && position_code < 14'h270b)
			position_code <= position_code + 14'h5;
		else if (drive_vent && position_code > 14'h4)
			position_code <= position_code - 14'h5;
	end
endmodule

// ===== verification/setpoint_ctrl_tb_top.sv
// self-checking bench for the setpoint block
`timescale 1ns/100ps
module setpoint_ctrl_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, manual_switch, pready, pslverr;
	logic        drive_aerate, drive_vent, preset_en, re;
	logic [7:0]  paddr, drive_gain;
	logic [31:0] pwdata, prdata, rq;
	logic [11:0] setpoint_code;
	logic [13:0] position_code, preset_val;
	int          err_count, total_checks;
	setpoint_ctrl #(.TICK_CYCLES(20)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.setpoint_code(setpoint_code), .position_code(position_code), .manual_switch(manual_switch),
		.drive_aerate(drive_aerate), .drive_vent(drive_vent), .drive_gain(drive_gain));
	actuator_model i_act (.pclk(pclk), .drive_aerate(drive_aerate), .drive_vent(drive_vent),
		.preset_en(preset_en), .preset_val(preset_val), .position_code(position_code));
	always #2.5 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one transfer; an edge passes first so no signal is assigned twice at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) chk(32'h1, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rq & m, exp);
		chk(32'(re), 32'h0);
	endtask
	task automatic t_defaults;
		rd(8'h00, 32'hf, 32'h0);
		rd(8'h04, 32'hffff, 32'h6400);
		rd(8'h08, 32'hffff, 32'h6400);
		rd(8'h0c, 32'hffff, 32'h0101);
		rd(8'h10, 32'hffffff, 32'h101001);
		apb(1'b0, 8'h30, 32'h0);
		chk(32'(re), 32'h1);
		apb(1'b0, 8'h06, 32'h0);
		chk(32'(re), 32'h1);
	endtask
	task automatic t_split;
		wr(8'h04, 32'h644c);
		rd(8'h04, 32'hffff, 32'h6400);
		rd(8'h18, 32'h1, 32'h1);
		wr(8'h18, 32'h1);
		wr(8'h04, 32'h644b);
		rd(8'h04, 32'hffff, 32'h644b);
		wr(8'h04, 32'h1900);
		wr(8'h04, 32'h1800);
		rd(8'h04, 32'hffff, 32'h1900);
	endtask
	task automatic t_limit;
		wr(8'h08, 32'h6433);
		rd(8'h08, 32'hffff, 32'h6400);
		wr(8'h08, 32'h3c0a);
		wr(8'h08, 32'h3c1e);
		rd(8'h08, 32'hffff, 32'h501e);
		wr(8'h08, 32'h371e);
		rd(8'h08, 32'hffff, 32'h3705);
	endtask
	task automatic t_position;
		preset_en <= 1'b1;
		preset_val <= 14'h03e8;
		wr(8'h08, 32'h4b19);
		repeat (60) @(posedge pclk);
		rd(8'h1c, 32'hffff, 32'hf448);
		wr(8'h00, 32'h7);
		rd(8'h00, 32'hf, 32'h7);
		repeat (60) @(posedge pclk);
		rd(8'h1c, 32'hffff, 32'h32c8);
		wr(8'h00, 32'h0);
	endtask
	task automatic t_time;
		wr(8'h0c, 32'h3c3c);
		wr(8'h0c, 32'h3d3c);
		wr(8'h0c, 32'h0000);
		rd(8'h0c, 32'hffff, 32'h3c3c);
	endtask
	task automatic t_cal;
		int n;
		n = 0;
		manual_switch <= 1'b1;
		wr(8'h14, 32'h2);
		repeat (60) @(posedge pclk);
		rd(8'h18, 32'h18, 32'h10);
		manual_switch <= 1'b0;
		preset_val <= 14'h0000;
		repeat (10) @(posedge pclk);
		preset_en <= 1'b0;
		wr(8'h14, 32'h2);
		repeat (300) @(posedge pclk);
		chk(32'(position_code > 14'h64), 32'h1);
		do rd(8'h18, 32'h0, 32'h0); while (rq[2:1] == 2'b00 && ++n < 4000);
		rd(8'h18, 32'he, 32'h2);
		rd(8'h0c, 32'hffff, 32'h0101);
		rd(8'h20, 32'hffff, 32'h0101);
		rd(8'h2c, 32'hffff, 32'h4b19);
	endtask
	task automatic t_factory;
		wr(8'h14, 32'h1);
		rd(8'h04, 32'hffff, 32'h6400);
		rd(8'h08, 32'hffff, 32'h6400);
		rd(8'h0c, 32'hffff, 32'h0101);
		// stem far above the ramp closes with the close gain; near it the deadband holds still
		wr(8'h10, 32'h302005);
		preset_en <= 1'b1;
		preset_val <= 14'h1388;
		repeat (60) @(posedge pclk);
		chk(32'({drive_aerate, drive_vent, drive_gain}), 32'h130);
		preset_val <= 14'h0000;
		repeat (60) @(posedge pclk);
		chk(32'({drive_aerate, drive_vent, drive_gain}), 32'h000);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// the whole run is some 5k cycles; this bound is far past it
	initial begin
		#500000;
		err_count++;
		wrap_up();
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, manual_switch, preset_en} = 7'h0;
		{paddr, pwdata, preset_val} = 54'h0;
		setpoint_code = 12'h333;
		err_count = 0;
		total_checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_split();
		t_limit();
		t_position();
		t_time();
		t_cal();
		t_factory();
		wrap_up();
	end
endmodule
